// ---- logic/timer3_pkg.sv ----
package timer3_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_CONTROL     = 5'h00;
    localparam logic [4:0] ADDR_MODE        = 5'h04;
    localparam logic [4:0] ADDR_MODE_B      = 5'h08;
    localparam logic [4:0] ADDR_COUNT_LOW   = 5'h0c;
    localparam logic [4:0] ADDR_COUNT_HIGH  = 5'h10;
    localparam logic [4:0] ADDR_RELOAD_LOW  = 5'h14;
    localparam logic [4:0] ADDR_RELOAD_HIGH = 5'h18;
    localparam logic [4:0] ADDR_STATUS      = 5'h1c;

    // ------------------------------------------------------------
    // Field positions: timer_control_reg
    // ------------------------------------------------------------
    localparam int CTL_OVF      = 7;
    localparam int CTL_EXT      = 6;
    localparam int CTL_SHARED5  = 5;
    localparam int CTL_SHARED4  = 4;
    localparam int CTL_FALL_EN  = 3;
    localparam int CTL_RUN_HIGH = 2;
    localparam int CTL_SRC_SEL  = 1;
    localparam int CTL_CAP_RLD  = 0;

    // ------------------------------------------------------------
    // Field positions: timer_mode_reg
    // ------------------------------------------------------------
    localparam int MOD_SPLIT     = 7;
    localparam int MOD_LOW_X12   = 6;
    localparam int MOD_RISE_EN   = 5;
    localparam int MOD_X12       = 4;
    localparam int MOD_RUN_LOW   = 3;
    localparam int MOD_AUTOCLEAR = 2;
    localparam int MOD_CLKOUT_EN = 1;
    localparam int MOD_BIT0      = 0;

    // ------------------------------------------------------------
    // Field positions: timer_mode_reg_b
    // ------------------------------------------------------------
    localparam int MODB_LOW_CS    = 7;
    localparam int MODB_OVF_IGN   = 6;
    localparam int MODB_BANK_SEL  = 5;
    localparam int MODB_CLK_GROUP = 4;
    localparam int MODB_BIT1      = 3;
    localparam int MODB_CAP_SRC   = 0;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam logic [3:0]  DIV12_LAST   = 4'hb;
    localparam logic [7:0]  BYTE_MAX     = 8'hff;
    localparam logic [15:0] WORD_MAX     = 16'hffff;

    // ------------------------------------------------------------
    // Clock source codes {group, x12, source}
    // ------------------------------------------------------------
    localparam logic [2:0] CLK_DIV12    = 3'h0;
    localparam logic [2:0] CLK_PIN      = 3'h1;
    localparam logic [2:0] CLK_SYS      = 3'h2;
    localparam logic [2:0] CLK_INT_EDGE = 3'h3;
    localparam logic [2:0] CLK_SER_OVF  = 3'h4;
    localparam logic [2:0] CLK_T0_OVF   = 3'h5;
    localparam logic [2:0] CLK_RESERVED = 3'h6;
    localparam logic [2:0] CLK_T1_OVF   = 3'h7;

    // Peripheral pulse input indices
    localparam int PER_INT_EDGE = 0;
    localparam int PER_SER_OVF  = 1;
    localparam int PER_T0_OVF   = 2;
    localparam int PER_T1_OVF   = 3;

endpackage

// ---- logic/timer3_reload_capture_split_pwm.sv ----
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps

module timer3_reload_capture_split_pwm #(
    parameter int ADDR_WIDTH = 5,
    parameter int EXT_INPUTS = 8
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire logic [ADDR_WIDTH-1:0] address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    input  wire logic [EXT_INPUTS-1:0] extEventPin,
    input  wire logic                  countPin,
    input  wire logic [3:0]            periphPulse,
    output logic                       irq,
    output logic                       overflowEvent,
    output logic                       clockOutPin,
    output logic                       rxClockSelect,
    output logic                       txClockSelect
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (ADDR_WIDTH < 5) begin : gAddrCheck
        $error("ADDR_WIDTH must be at least 5");
    end
    if (EXT_INPUTS != 8) begin : gExtCheck
        $error("EXT_INPUTS must be 8, selected by a 3-bit field");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  ctl;
        logic [7:0]  mode;
        logic [7:0]  modeB;
        logic [15:0] cnt;
        logic [15:0] rld;
        logic        rxSel, txSel, flagLow, lowIrqEn;
        logic [3:0]  div12;
        logic        syncA, syncB, prevEv, prevPin;
        logic        clkTog, ovEvt, clkOut, irq, waitReq;
        logic [31:0] readData;
    } state_s;

    localparam state_s ST_RESET = '{
        ctl: timer3_pkg::RESET_BYTE, mode: timer3_pkg::RESET_BYTE,
        modeB: timer3_pkg::RESET_BYTE, cnt: timer3_pkg::RESET_WORD,
        rld: timer3_pkg::RESET_WORD, div12: 4'h0, waitReq: 1'b1,
        readData: 32'h0000_0000, default: 1'b0
    };

    state_s st;
    state_s next_st;

    logic        extSel, fallEdge, riseEdge, extEdge, div12Pulse, pinPulse;
    logic        split, pwmMode, capMode, zeroMode;
    logic        tick16, tickHigh, tickLow, ov16, ovHigh, ovLow;
    logic [2:0]  srcCode;
    logic [1:0]  lowCode;
    logic        srcTick, lowSrcTick, busWrite, busTake;
    logic [4:0]  regAddr;
    logic [31:0] readMux;

    assign regAddr = address[4:0];

    // ------------------------------------------------------------
    // Event input and clock sources
    // ------------------------------------------------------------
    assign extSel     = extEventPin[st.modeB[timer3_pkg::MODB_CAP_SRC +: 3]];
    assign fallEdge   = st.prevEv & ~st.syncB;
    assign riseEdge   = ~st.prevEv & st.syncB;
    assign extEdge    = (fallEdge & st.ctl[timer3_pkg::CTL_FALL_EN])
                      | (riseEdge & st.mode[timer3_pkg::MOD_RISE_EN]);
    assign div12Pulse = (st.div12 == timer3_pkg::DIV12_LAST);
    assign pinPulse   = st.prevPin & ~countPin;

    assign split    = st.mode[timer3_pkg::MOD_SPLIT];
    assign pwmMode  = split & st.modeB[timer3_pkg::MODB_BIT1];
    assign capMode  = st.ctl[timer3_pkg::CTL_CAP_RLD];
    assign zeroMode = capMode & st.mode[timer3_pkg::MOD_BIT0];

    assign srcCode = {st.modeB[timer3_pkg::MODB_CLK_GROUP], st.mode[timer3_pkg::MOD_X12],
                      st.ctl[timer3_pkg::CTL_SRC_SEL]};
    assign lowCode = {st.modeB[timer3_pkg::MODB_LOW_CS], st.mode[timer3_pkg::MOD_LOW_X12]};

    // Low-byte side first: the high byte may cascade from it
    always_comb
    begin
        unique case (lowCode)
            2'h0: lowSrcTick = div12Pulse;
            2'h1: lowSrcTick = 1'b1;
            2'h2: lowSrcTick = periphPulse[timer3_pkg::PER_SER_OVF];
            2'h3: lowSrcTick = periphPulse[timer3_pkg::PER_INT_EDGE];
        endcase
    end

    assign tickLow = split & ~pwmMode & st.mode[timer3_pkg::MOD_RUN_LOW] & lowSrcTick;
    assign ovLow   = tickLow & (st.cnt[7:0] == timer3_pkg::BYTE_MAX);

    always_comb
    begin
        unique case (srcCode)
            timer3_pkg::CLK_DIV12:    srcTick = div12Pulse;
            timer3_pkg::CLK_PIN:      srcTick = pinPulse;
            timer3_pkg::CLK_SYS:      srcTick = 1'b1;
            timer3_pkg::CLK_INT_EDGE: srcTick = split ? ovLow
                                              : periphPulse[timer3_pkg::PER_INT_EDGE];
            timer3_pkg::CLK_SER_OVF:  srcTick = periphPulse[timer3_pkg::PER_SER_OVF];
            timer3_pkg::CLK_T0_OVF:   srcTick = periphPulse[timer3_pkg::PER_T0_OVF];
            timer3_pkg::CLK_RESERVED: srcTick = 1'b0;
            timer3_pkg::CLK_T1_OVF:   srcTick = periphPulse[timer3_pkg::PER_T1_OVF];
        endcase
    end

    assign tick16   = ~split & st.ctl[timer3_pkg::CTL_RUN_HIGH] & srcTick;
    assign ov16     = tick16 & (st.cnt == timer3_pkg::WORD_MAX);
    assign tickHigh = split & st.ctl[timer3_pkg::CTL_RUN_HIGH] & srcTick;
    assign ovHigh   = tickHigh & (st.cnt[15:8] == timer3_pkg::BYTE_MAX);

    assign busWrite = write & ~st.waitReq & byteenable[0];
    assign busTake  = (read | write) & st.waitReq;

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    always_comb
    begin
        readMux = 32'h0000_0000;
        unique case (regAddr)
            timer3_pkg::ADDR_CONTROL:
            begin
                readMux[7:0] = st.ctl;
                readMux[timer3_pkg::CTL_SHARED5] = st.modeB[timer3_pkg::MODB_BANK_SEL]
                                                   ? st.flagLow : st.rxSel;
                readMux[timer3_pkg::CTL_SHARED4] = st.modeB[timer3_pkg::MODB_BANK_SEL]
                                                   ? st.lowIrqEn : st.txSel;
            end
            timer3_pkg::ADDR_MODE:        readMux[7:0] = st.mode;
            timer3_pkg::ADDR_MODE_B:      readMux[7:0] = st.modeB;
            timer3_pkg::ADDR_COUNT_LOW:   readMux[7:0] = st.cnt[7:0];
            timer3_pkg::ADDR_COUNT_HIGH:  readMux[7:0] = st.cnt[15:8];
            timer3_pkg::ADDR_RELOAD_LOW:  readMux[7:0] = st.rld[7:0];
            timer3_pkg::ADDR_RELOAD_HIGH: readMux[7:0] = st.rld[15:8];
            timer3_pkg::ADDR_STATUS:      readMux[2:0] = {st.irq, st.clkOut, st.syncB};
            default:                      readMux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;

        // Bus handshake: one wait cycle, then the access completes
        next_st.waitReq = ~busTake;
        if (busTake)
        begin
            next_st.readData = readMux;
        end

        // Synchroniser and edge history
        next_st.syncA   = extSel;
        next_st.syncB   = st.syncA;
        next_st.prevEv  = st.syncB;
        next_st.prevPin = countPin;
        next_st.div12   = div12Pulse ? 4'h0 : st.div12 + 4'h1;

        // Counting
        if (!split)
        begin
            if (tick16)
            begin
                next_st.cnt = st.cnt + 16'h0001;
            end
            if (!capMode)
            begin
                if (ov16 || (extEdge && st.mode[timer3_pkg::MOD_BIT0]))
                begin
                    next_st.cnt = st.rld;
                end
            end
            else if (extEdge)
            begin
                next_st.rld = st.cnt;
                if (zeroMode)
                begin
                    next_st.cnt = timer3_pkg::RESET_WORD;
                end
            end
        end
        else if (pwmMode)
        begin
            if (tickHigh)
            begin
                next_st.cnt[15:8] = st.cnt[15:8] + 8'h01;
            end
            if (ovHigh)
            begin
                next_st.cnt[15:8] = st.rld[15:8];
                next_st.cnt[7:0]  = st.rld[7:0];
            end
        end
        else
        begin
            if (tickHigh)
            begin
                next_st.cnt[15:8] = st.cnt[15:8] + 8'h01;
            end
            if (tickLow)
            begin
                next_st.cnt[7:0] = st.cnt[7:0] + 8'h01;
            end
            if (!capMode)
            begin
                if (ovHigh || (extEdge && st.mode[timer3_pkg::MOD_BIT0]))
                begin
                    next_st.cnt[15:8] = st.rld[15:8];
                end
                if (ovLow || (extEdge && st.mode[timer3_pkg::MOD_BIT0]))
                begin
                    next_st.cnt[7:0] = st.rld[7:0];
                end
            end
            else if (extEdge)
            begin
                next_st.rld = st.cnt;
                if (zeroMode)
                begin
                    next_st.cnt = timer3_pkg::RESET_WORD;
                end
            end
            // Low run autoclear; a software write in the same cycle wins
            if (st.mode[timer3_pkg::MOD_AUTOCLEAR]
                && ((!capMode && ovHigh) || (capMode && extEdge)))
            begin
                next_st.mode[timer3_pkg::MOD_RUN_LOW] = 1'b0;
            end
        end

        // Software writes
        if (busWrite)
        begin
            unique case (regAddr)
                timer3_pkg::ADDR_CONTROL:
                begin
                    next_st.ctl = writedata[7:0];
                    if (st.modeB[timer3_pkg::MODB_BANK_SEL])
                    begin
                        next_st.flagLow  = writedata[timer3_pkg::CTL_SHARED5];
                        next_st.lowIrqEn = writedata[timer3_pkg::CTL_SHARED4];
                    end
                    else
                    begin
                        next_st.rxSel = writedata[timer3_pkg::CTL_SHARED5];
                        next_st.txSel = writedata[timer3_pkg::CTL_SHARED4];
                    end
                end
                timer3_pkg::ADDR_MODE:        next_st.mode       = writedata[7:0];
                timer3_pkg::ADDR_MODE_B:      next_st.modeB      = writedata[7:0];
                timer3_pkg::ADDR_COUNT_LOW:   next_st.cnt[7:0]   = writedata[7:0];
                timer3_pkg::ADDR_COUNT_HIGH:  next_st.cnt[15:8]  = writedata[7:0];
                timer3_pkg::ADDR_RELOAD_LOW:  next_st.rld[7:0]   = writedata[7:0];
                timer3_pkg::ADDR_RELOAD_HIGH: next_st.rld[15:8]  = writedata[7:0];
                default:                      next_st.ctl        = st.ctl;
            endcase
        end
        // Shared bits live outside the control byte
        next_st.ctl[timer3_pkg::CTL_SHARED5] = 1'b0;
        next_st.ctl[timer3_pkg::CTL_SHARED4] = 1'b0;

        // Hardware sets applied last so they beat a same-cycle clear
        if (ov16 || ovHigh)
        begin
            next_st.ctl[timer3_pkg::CTL_OVF] = 1'b1;
        end
        if (extEdge)
        begin
            next_st.ctl[timer3_pkg::CTL_EXT] = 1'b1;
        end
        if (ovLow)
        begin
            next_st.flagLow = 1'b1;
        end

        // Exported event and clock output
        next_st.ovEvt = split ? ovLow : ov16;
        if (!capMode && st.mode[timer3_pkg::MOD_CLKOUT_EN] && next_st.ovEvt)
        begin
            next_st.clkTog = ~st.clkTog;
        end
        // Counter below compare drives the pulse high
        next_st.clkOut = next_st.mode[timer3_pkg::MOD_CLKOUT_EN]
                       & (pwmMode ? (next_st.cnt[15:8] < next_st.cnt[7:0])
                                  : next_st.clkTog);

        // Shared interrupt request
        next_st.irq = (next_st.ctl[timer3_pkg::CTL_OVF]
                       & ~next_st.modeB[timer3_pkg::MODB_OVF_IGN])
                    | next_st.ctl[timer3_pkg::CTL_EXT]
                    | (next_st.flagLow & next_st.lowIrqEn);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            st <= ST_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign readdata      = st.readData;
    assign waitrequest   = st.waitReq;
    assign irq           = st.irq;
    assign overflowEvent = st.ovEvt;
    assign clockOutPin   = st.clkOut;
    assign rxClockSelect = st.rxSel;
    assign txClockSelect = st.txSel;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    ovf_flag_set_a: assert property (ov16 |=> st.ctl[timer3_pkg::CTL_OVF])
        else $error("overflow did not set the overflow flag");

    reload_word_a: assert property (ov16 && !capMode && !busWrite
                                    |=> st.cnt == $past(st.rld))
        else $error("16-bit reload value wrong");

    capture_word_a: assert property (!split && capMode && extEdge && !busWrite
                                     |=> st.rld == $past(st.cnt))
        else $error("capture missed the count");

    auto_zero_a: assert property (!split && zeroMode && extEdge && !busWrite
                                  |=> st.cnt == 16'h0000)
        else $error("auto-zero did not clear the count");

    ext_flag_set_a: assert property ($fell(st.syncB) && st.ctl[timer3_pkg::CTL_FALL_EN]
                                     |-> ##1 st.ctl[timer3_pkg::CTL_EXT])
        else $error("falling edge did not set external flag");

    irq_tie_a: assert property (st.ctl[timer3_pkg::CTL_EXT] |-> irq)
        else $error("external flag without interrupt request");

    low_ovf_flag_a: assert property (ovLow |=> st.flagLow && overflowEvent)
        else $error("low overflow not flagged or exported");

    clkout_gate_a: assert property (!st.mode[timer3_pkg::MOD_CLKOUT_EN] |-> !clockOutPin)
        else $error("clock output active while disabled");

    bus_wait_a: assert property ((read || write) && waitrequest ##1 (read || write)
                                 |-> !waitrequest ##1 waitrequest)
        else $error("bus handshake timing wrong");

endmodule

// ---- verification/event_source.sv ----
`timescale 1ns/1ps
// Unused pins rest high, like pins with pull-ups; periphPulse rests low
module event_source (
    input  wire logic       sys_clk,
    output logic      [7:0] extEventPin = 8'hff,
    output logic            countPin    = 1'b1,
    output logic      [3:0] periphPulse = 4'h0
);
    task automatic setEvent(input logic lvl);
        @(posedge sys_clk);
        extEventPin[0] <= lvl;
    endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
    logic        waitrequest, irq, overflowEvent, clockOutPin, rxClockSelect, txClockSelect;
    logic        countPin;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0, readdata;
    logic [3:0]  byteenable = 4'h1, periphPulse;
    logic [7:0]  extEventPin, rd, gap;
    int          errTotal, testsRun;
    timer3_reload_capture_split_pwm DUT (
        .sys_clk, .rst_b, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .extEventPin, .countPin, .periphPulse, .irq, .overflowEvent,
        .clockOutPin, .rxClockSelect, .txClockSelect
    );
    event_source partner (.sys_clk, .extEventPin, .countPin, .periphPulse);
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        address   <= a;
        writedata <= {24'h0, d};
        write     <= wr;
        read      <= !wr;
        // Held until the edge that sees waitrequest low, never earlier
        @(posedge sys_clk);
        while (waitrequest !== 1'b0)
            @(posedge sys_clk);
        rd = readdata[7:0];
        write <= 1'b0;
        read  <= 1'b0;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            errTotal++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic peek(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd, exp);
    endtask
    task automatic testRegs();
        bus(1'b1, 5'h02, 8'hff);
        for (int i = 0; i < 7; i++)
            peek(5'(4 * i), 8'h00);
        peek(5'h02, 8'h00);
        bus(1'b1, 5'h00, 8'h10);
        @(posedge sys_clk);
        check({6'h0, rxClockSelect, txClockSelect}, 8'h01);
        $display("register test done");
    endtask
    task automatic testOverflow();
        bus(1'b1, 5'h04, 8'h12);
        bus(1'b1, 5'h18, 8'hff);
        bus(1'b1, 5'h14, 8'hf0);
        bus(1'b1, 5'h10, 8'hff);
        bus(1'b1, 5'h0c, 8'hf0);
        bus(1'b1, 5'h00, 8'h04);
        while (overflowEvent !== 1'b1)
            @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        check({7'h0, irq}, 8'h01);
        check({7'h0, clockOutPin}, 8'h01);
        gap = 8'h02;
        do
        begin
            @(posedge sys_clk);
            gap++;
        end
        while (overflowEvent !== 1'b1);
        check(gap, 8'h10);
        check({7'h0, clockOutPin}, 8'h00);
        peek(5'h00, 8'h84);
        bus(1'b1, 5'h00, 8'h00);
        peek(5'h00, 8'h00);
        bus(1'b1, 5'h08, 8'h40);
        bus(1'b1, 5'h0c, 8'hf0);
        bus(1'b1, 5'h00, 8'h04);
        repeat (20) @(posedge sys_clk);
        check({7'h0, irq}, 8'h00);
        peek(5'h00, 8'h84);
        bus(1'b1, 5'h00, 8'h00);
        $display("overflow test done");
    endtask
    task automatic testEvents();
        bus(1'b1, 5'h0c, 8'h34);
        bus(1'b1, 5'h10, 8'h12);
        bus(1'b1, 5'h04, 8'h01);
        bus(1'b1, 5'h00, 8'h09);
        partner.setEvent(1'b0);
        repeat (6) @(posedge sys_clk);
        check({7'h0, irq}, 8'h01);
        peek(5'h14, 8'h34);
        peek(5'h18, 8'h12);
        peek(5'h0c, 8'h00);
        peek(5'h00, 8'h49);
        bus(1'b1, 5'h00, 8'h00);
        bus(1'b1, 5'h04, 8'h20);
        partner.setEvent(1'b1);
        repeat (6) @(posedge sys_clk);
        peek(5'h00, 8'h40);
        bus(1'b1, 5'h00, 8'h00);
        partner.setEvent(1'b0);
        repeat (6) @(posedge sys_clk);
        peek(5'h00, 8'h00);
        bus(1'b1, 5'h04, 8'h21);
        partner.setEvent(1'b1);
        repeat (6) @(posedge sys_clk);
        peek(5'h10, 8'h12);
        peek(5'h00, 8'h40);
        bus(1'b1, 5'h00, 8'h00);
        $display("event test done");
    endtask
    task automatic testSplit();
        bus(1'b1, 5'h08, 8'h20);
        bus(1'b1, 5'h14, 8'hf8);
        bus(1'b1, 5'h0c, 8'hf8);
        bus(1'b1, 5'h18, 8'hf0);
        bus(1'b1, 5'h10, 8'hf0);
        bus(1'b1, 5'h04, 8'hdc);
        bus(1'b1, 5'h00, 8'h14);
        while (overflowEvent !== 1'b1)
            @(posedge sys_clk);
        check({7'h0, irq}, 8'h01);
        repeat (40) @(posedge sys_clk);
        peek(5'h04, 8'hd4);
        peek(5'h0c, 8'hfb);
        peek(5'h00, 8'hb4);
        bus(1'b1, 5'h04, 8'h00);
        $display("split test done");
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        testRegs();
        testOverflow();
        testEvents();
        testSplit();
        summarize();
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        errTotal++;
        summarize();
    end
endmodule
